// ### verilog/ssis_pkg.sv
// shared constants and types of the serial status and interrupt block
package ssis_pkg;

  // register port geometry
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int NUM_SRC    = 12;
  localparam int NUM_STICKY = 5;
  localparam int CNT_W_DEF  = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SET  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;

  // status bit positions, bits 0 to 11 also enable, disable and mask bit positions
  localparam int BIT_TX_FREE    = 0;
  localparam int BIT_TX_DRAINED = 1;
  localparam int BIT_TX_DMA_END = 2;
  localparam int BIT_TX_BUF_MT  = 3;
  localparam int BIT_RX_AVAIL   = 4;
  localparam int BIT_OVERRUN    = 5;
  localparam int BIT_RX_DMA_END = 6;
  localparam int BIT_RX_BUF_FUL = 7;
  localparam int BIT_CP0        = 8;
  localparam int BIT_CP1        = 9;
  localparam int BIT_TX_SYNC    = 10;
  localparam int BIT_RX_SYNC    = 11;
  localparam int BIT_TX_ON      = 16;
  localparam int BIT_RX_ON      = 17;

  // positions inside the sticky flag vector
  localparam int STK_OVERRUN = 0;
  localparam int STK_CP0     = 1;
  localparam int STK_CP1     = 2;
  localparam int STK_TX_SYNC = 3;
  localparam int STK_RX_SYNC = 4;

  // reset values
  localparam logic [NUM_SRC-1:0]    MASK_RESET  = 12'h000;
  localparam logic [NUM_STICKY-1:0] FLAG_RESET  = 5'h00;
  localparam logic [DATA_W-1:0]     RDATA_RESET = 32'h00000000;

  typedef enum {SSIS_SEL_STATUS, SSIS_SEL_SET, SSIS_SEL_CLR, SSIS_SEL_MASK, SSIS_SEL_NONE}
    ssis_sel_e;

  // address decode shared by the read and write paths
  function automatic ssis_sel_e ssis_decode(input logic [ADDR_W-1:0] addr);
    ssis_sel_e sel;
    sel = SSIS_SEL_NONE;
    case (addr)
      OFS_STATUS:   sel = SSIS_SEL_STATUS;
      OFS_IRQ_SET:  sel = SSIS_SEL_SET;
      OFS_IRQ_CLR:  sel = SSIS_SEL_CLR;
      OFS_IRQ_MASK: sel = SSIS_SEL_MASK;
      default:      sel = SSIS_SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage

// ### verilog/ssis_bits_if.sv
// set/clear/value bundle between the top and its bit-store modules
interface ssis_bits_if #(parameter int W = 1);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport ctrl  (output set, output clr, input q);
  modport store (input set, input clr, output q);
endinterface

// ### verilog/ssis_sticky_flags.sv
// sticky event flags, set wins over clear
module ssis_sticky_flags import ssis_pkg::*; #(
  parameter int W = NUM_STICKY
) (
  // clock and reset
  input wire logic  clock,
  input wire logic  arst_n,
  input wire logic  clk_en,
  // flag bundle
  ssis_bits_if.store bits
);

  logic [W-1:0] flag_r;
  logic [W-1:0] flag_nxt;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      always_comb begin
        flag_nxt[i] = flag_r[i];
        if (clk_en) begin
          flag_nxt[i] = bits.set[i] | (flag_r[i] & ~bits.clr[i]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= FLAG_RESET[W-1:0];
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign bits.q = flag_r;

  chk_set_beats_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && (bits.set != '0)) |=> ((flag_r & $past(bits.set)) == $past(bits.set)))
    else $error("event lost against a simultaneous clear");

endmodule

// ### verilog/ssis_mask_reg.sv
// interrupt mask with separate set and clear write ports
module ssis_mask_reg import ssis_pkg::*; #(
  parameter int W = NUM_SRC
) (
  // clock and reset
  input wire logic  clock,
  input wire logic  arst_n,
  input wire logic  clk_en,
  // mask bundle
  ssis_bits_if.store bits
);

  logic [W-1:0] mask_r;
  logic [W-1:0] mask_nxt;

  always_comb begin
    mask_nxt = mask_r;
    if (clk_en) begin
      mask_nxt = (mask_r | bits.set) & ~bits.clr;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= MASK_RESET[W-1:0];
    end else begin
      mask_r <= mask_nxt;
    end
  end

  assign bits.q = mask_r;

endmodule

// ### verilog/ssis_top.sv
// status flags, interrupt mask and register port of the serial controller
module ssis_top import ssis_pkg::*; #(
  parameter int CNT_W = CNT_W_DEF
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // transmit side state
  input  wire logic              transmit_holding_free,
  input  wire logic              transmit_all_drained,
  input  wire logic              transmit_dma_end,
  input  wire logic [CNT_W-1:0]  transmit_dma_counter,
  input  wire logic [CNT_W-1:0]  transmit_dma_next_counter,
  input  wire logic              transmitter_on,
  // receive side state
  input  wire logic              receive_word_available,
  input  wire logic              receive_dma_end,
  input  wire logic [CNT_W-1:0]  receive_dma_counter,
  input  wire logic [CNT_W-1:0]  receive_dma_next_counter,
  input  wire logic              receive_word_loaded,
  input  wire logic              receive_holding_word_read,
  input  wire logic              receiver_on,
  // event pulses
  input  wire logic              compare_zero_hit,
  input  wire logic              compare_one_hit,
  input  wire logic              transmit_frame_sync_seen,
  input  wire logic              receive_frame_sync_seen,
  // interrupt
  output logic                   irq
);

  ssis_bits_if #(.W(NUM_STICKY)) flag_bus ();
  ssis_bits_if #(.W(NUM_SRC))    mask_bus ();

  ssis_sel_e          sel;
  logic               status_read;
  logic               rx_pending_r;
  logic               rx_pending_nxt;
  logic               overrun_evt;
  logic               rx_bufs_zero;
  logic               tx_bufs_zero;
  logic [NUM_SRC-1:0] wdata_src;
  logic [NUM_SRC-1:0] mask_q;
  logic [DATA_W-1:0]  status_word;
  logic [DATA_W-1:0]  rdata_r;
  logic [DATA_W-1:0]  rdata_nxt;

  ssis_sticky_flags #(.W(NUM_STICKY)) u_flags (
    .clock  (clock),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .bits   (flag_bus.store)
  );

  ssis_mask_reg #(.W(NUM_SRC)) u_mask (
    .clock  (clock),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .bits   (mask_bus.store)
  );

  assign sel         = ssis_decode(reg_addr);
  assign status_read = clk_en && reg_rd && (sel == SSIS_SEL_STATUS);
  assign wdata_src   = reg_wdata[NUM_SRC-1:0];
  assign mask_q      = mask_bus.q;

  // dma counter views
  assign rx_bufs_zero = (receive_dma_counter == '0) && (receive_dma_next_counter == '0);
  assign tx_bufs_zero = (transmit_dma_counter == '0) && (transmit_dma_next_counter == '0);

  // unread word tracking for overrun
  always_comb begin
    rx_pending_nxt = rx_pending_r;
    if (clk_en) begin
      rx_pending_nxt = receive_word_loaded | (rx_pending_r & ~receive_holding_word_read);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_pending_r <= 1'b0;
    end else begin
      rx_pending_r <= rx_pending_nxt;
    end
  end

  // read of the old word in the load cycle counts as taken in time
  assign overrun_evt = receive_word_loaded & rx_pending_r & ~receive_holding_word_read;

  // sticky flag sources, all cleared by a status read
  always_comb begin
    flag_bus.set              = '0;
    flag_bus.set[STK_OVERRUN] = overrun_evt;
    flag_bus.set[STK_CP0]     = compare_zero_hit;
    flag_bus.set[STK_CP1]     = compare_one_hit;
    flag_bus.set[STK_TX_SYNC] = transmit_frame_sync_seen;
    flag_bus.set[STK_RX_SYNC] = receive_frame_sync_seen;
    flag_bus.clr              = {NUM_STICKY{status_read}};
  end

  // mask writes, only the low source bits are taken
  always_comb begin
    mask_bus.set = '0;
    mask_bus.clr = '0;
    if (reg_wr && (sel == SSIS_SEL_SET)) begin
      mask_bus.set = wdata_src;
    end
    if (reg_wr && (sel == SSIS_SEL_CLR)) begin
      mask_bus.clr = wdata_src;
    end
  end

  // status word assembly
  always_comb begin
    status_word                 = '0;
    status_word[BIT_TX_FREE]    = transmit_holding_free;
    status_word[BIT_TX_DRAINED] = transmit_all_drained;
    status_word[BIT_TX_DMA_END] = transmit_dma_end;
    status_word[BIT_TX_BUF_MT]  = tx_bufs_zero;
    status_word[BIT_RX_AVAIL]   = receive_word_available;
    status_word[BIT_OVERRUN]    = flag_bus.q[STK_OVERRUN];
    status_word[BIT_RX_DMA_END] = receive_dma_end;
    status_word[BIT_RX_BUF_FUL] = rx_bufs_zero;
    status_word[BIT_CP0]        = flag_bus.q[STK_CP0];
    status_word[BIT_CP1]        = flag_bus.q[STK_CP1];
    status_word[BIT_TX_SYNC]    = flag_bus.q[STK_TX_SYNC];
    status_word[BIT_RX_SYNC]    = flag_bus.q[STK_RX_SYNC];
    status_word[BIT_TX_ON]      = transmitter_on;
    status_word[BIT_RX_ON]      = receiver_on;
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (clk_en) begin
      rdata_nxt = RDATA_RESET;
      if (reg_rd) begin
        case (sel)
          SSIS_SEL_STATUS: rdata_nxt = status_word;
          SSIS_SEL_MASK:   rdata_nxt = {{(DATA_W-NUM_SRC){1'b0}}, mask_q};
          default:         rdata_nxt = RDATA_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= RDATA_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = |(status_word[NUM_SRC-1:0] & mask_q);

  chk_rxbuf_full_read: assert property (@(posedge clock) disable iff (!arst_n)
    status_read |=> (reg_rdata[BIT_RX_BUF_FUL] == $past(rx_bufs_zero)))
    else $error("receive buffer full bit wrong");

  chk_cp0_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && compare_zero_hit) |=> status_word[BIT_CP0])
    else $error("compare zero flag not set");

  chk_cp0_read_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (status_read && !compare_zero_hit) |=> !status_word[BIT_CP0])
    else $error("compare zero flag survives status read");

  chk_cp1_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && compare_one_hit && !status_read) |=>
      status_word[BIT_CP1] ##1 (status_word[BIT_CP1] || $past(status_read)))
    else $error("compare one flag not held");

  chk_tx_sync_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && transmit_frame_sync_seen) |=>
      status_word[BIT_TX_SYNC] ##1 (status_word[BIT_TX_SYNC] || $past(status_read)))
    else $error("tx sync flag dropped before status read");

  chk_rx_sync_clear: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(status_word[BIT_RX_SYNC]) |-> $past(status_read))
    else $error("rx sync flag cleared without status read");

  chk_tx_on_view: assert property (@(posedge clock) disable iff (!arst_n)
    status_read |=> (reg_rdata[BIT_TX_ON] == $past(transmitter_on)))
    else $error("transmitter enable bit wrong");

  chk_rx_on_view: assert property (@(posedge clock) disable iff (!arst_n)
    status_read |=> (reg_rdata[BIT_RX_ON] == $past(receiver_on)))
    else $error("receiver enable bit wrong");

  chk_mask_set_bits: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && reg_wr && (sel == SSIS_SEL_SET)) |=>
      (((mask_q & $past(wdata_src)) == $past(wdata_src)) &&
       (((mask_q ^ $past(mask_q)) & ~$past(wdata_src)) == '0)))
    else $error("mask set write wrong");

  chk_mask_clr_bits: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && reg_wr && (sel == SSIS_SEL_CLR)) |=>
      (((mask_q & $past(wdata_src)) == '0) &&
       (((mask_q ^ $past(mask_q)) & ~$past(wdata_src)) == '0)))
    else $error("mask clear write wrong");

  chk_mask_readback: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && reg_rd && (sel == SSIS_SEL_MASK)) |=>
      (reg_rdata == {{(DATA_W-NUM_SRC){1'b0}}, $past(mask_q)}))
    else $error("mask read back wrong");

  chk_layout_low: assert property (@(posedge clock) disable iff (!arst_n)
    status_read |=> ((reg_rdata[BIT_TX_FREE] == $past(transmit_holding_free)) &&
                     (reg_rdata[BIT_RX_AVAIL] == $past(receive_word_available))))
    else $error("status layout wrong");

  chk_overrun_irq: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && reg_wr && (sel == SSIS_SEL_SET) && reg_wdata[BIT_OVERRUN] &&
     status_word[BIT_OVERRUN]) |=> irq)
    else $error("enabled overrun does not interrupt");

  chk_overrun_set: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && receive_word_loaded && rx_pending_r && !receive_holding_word_read) |=>
      status_word[BIT_OVERRUN])
    else $error("overrun not flagged");

  chk_irq_masked: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && reg_wr && (sel == SSIS_SEL_CLR) && (reg_wdata[NUM_SRC-1:0] == 12'hFFF))
      |=> !irq)
    else $error("interrupt with all sources disabled");

  chk_upper_zero: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && reg_rd && (sel == SSIS_SEL_MASK)) |=> (reg_rdata[DATA_W-1:NUM_SRC] == '0))
    else $error("reserved mask bits not zero");

  chk_cp1_read_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (status_read && !compare_one_hit) |=> !status_word[BIT_CP1])
    else $error("compare one flag survives status read");

  chk_tx_sync_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (status_read && !transmit_frame_sync_seen) |=> !status_word[BIT_TX_SYNC])
    else $error("tx sync flag survives status read");

  chk_rx_sync_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && receive_frame_sync_seen) |=> status_word[BIT_RX_SYNC])
    else $error("rx sync flag not set");

  chk_cp0_held: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(status_word[BIT_CP0]) |-> $past(status_read))
    else $error("compare zero flag cleared without status read");

  chk_txbuf_empty_read: assert property (@(posedge clock) disable iff (!arst_n)
    status_read |=> (reg_rdata[BIT_TX_BUF_MT] == (($past(transmit_dma_counter) == '0) &&
                     ($past(transmit_dma_next_counter) == '0))))
    else $error("transmit buffer empty bit wrong");

  chk_status_reserved: assert property (@(posedge clock) disable iff (!arst_n)
    status_read |=> ((reg_rdata[BIT_TX_ON-1:NUM_SRC] == '0) &&
                     (reg_rdata[DATA_W-1:BIT_RX_ON+1] == '0)))
    else $error("reserved status bits not zero");

  chk_overrun_quiet: assert property (@(posedge clock) disable iff (!arst_n)
    (!status_word[BIT_OVERRUN] && !(receive_word_loaded && rx_pending_r)) |=>
      !status_word[BIT_OVERRUN])
    else $error("overrun flagged without an overwrite");

  chk_mask_frozen: assert property (@(posedge clock) disable iff (!arst_n)
    !clk_en |=> (mask_q == $past(mask_q)))
    else $error("mask changed while frozen");

  chk_rdata_frozen: assert property (@(posedge clock) disable iff (!arst_n)
    !clk_en |=> $stable(reg_rdata))
    else $error("read data changed while frozen");

  chk_rdata_idle_zero: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && !reg_rd) |=> (reg_rdata == '0))
    else $error("read data not zero outside a read");

  chk_wo_ports_zero: assert property (@(posedge clock) disable iff (!arst_n)
    (clk_en && reg_rd && ((sel == SSIS_SEL_SET) || (sel == SSIS_SEL_CLR))) |=>
      (reg_rdata == '0))
    else $error("write-only port read not zero");

  chk_irq_none_enabled: assert property (@(posedge clock) disable iff (!arst_n)
    (mask_q == '0) |-> !irq)
    else $error("interrupt with empty mask");

  chk_overrun_irq_level: assert property (@(posedge clock) disable iff (!arst_n)
    (status_word[BIT_OVERRUN] && mask_q[BIT_OVERRUN]) |-> irq)
    else $error("enabled overrun flag without interrupt");

endmodule

// ### tb/ssis_top_tb.sv
// self-checking bench of the serial status and interrupt block
module ssis_top_tb import ssis_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock;
  logic              arst_n;
  logic              clk_en;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic [6:0]        lv;
  logic [15:0]       tx_c;
  logic [15:0]       tx_n;
  logic [15:0]       rx_c;
  logic [15:0]       rx_n;
  logic [5:0]        ev;
  logic              irq;
  logic [11:0]       m;
  logic [31:0]       sk;
  logic [31:0]       rs;
  logic              pend;
  logic              rd_d1;
  logic [31:0]       exp_q[$];
  int                mismatches;
  int                n_checks;
  int                cyc;

  ssis_top #(.CNT_W(16)) i_dut (
    .clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .transmit_holding_free(lv[0]), .transmit_all_drained(lv[1]), .transmit_dma_end(lv[2]),
    .transmit_dma_counter(tx_c), .transmit_dma_next_counter(tx_n), .transmitter_on(lv[5]),
    .receive_word_available(lv[3]), .receive_dma_end(lv[4]), .receive_dma_counter(rx_c),
    .receive_dma_next_counter(rx_n), .receive_word_loaded(ev[4]),
    .receive_holding_word_read(ev[5]), .receiver_on(lv[6]),
    .compare_zero_hit(ev[0]), .compare_one_hit(ev[1]),
    .transmit_frame_sync_seen(ev[2]), .receive_frame_sync_seen(ev[3]),
    .irq(irq)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // expected status word from the bench's own view of inputs and events
  function automatic logic [31:0] st();
    return {14'h0000, lv[6], lv[5], 4'h0, sk[11:8], ~|{rx_c, rx_n}, lv[4], sk[5], lv[3],
            ~|{tx_c, tx_n}, lv[2:0]};
  endfunction

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    if (clk_en && a == OFS_IRQ_SET) m = m | d[11:0];
    if (clk_en && a == OFS_IRQ_CLR) m = m & ~d[11:0];
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_wr   <= 1'b0;
    reg_addr <= a;
    if (a == OFS_STATUS) begin
      exp_q.push_back(st());
      sk = 32'h00000000;
    end else begin
      exp_q.push_back(a == OFS_IRQ_MASK ? {20'h00000, m} : 32'h00000000);
    end
  endtask

  task automatic idle();
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
  endtask

  task automatic pulse(input int i);
    idle();
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
    if (i < 4) sk[8 + i] = 1'b1;
    if (i == 4 && pend) sk[5] = 1'b1;
    if (i == 4) pend = 1'b1;
    if (i == 5) pend = 1'b0;
  endtask

  task automatic ck_irq();
    logic [31:0] s;
    #1;
    s = st();
    chk("irq", {31'h00000000, |(s[11:0] & m)}, {31'h00000000, irq});
  endtask

  // result watcher: read data stand in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_d1) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    rd_d1 <= reg_rd & clk_en;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    arst_n = 1'b0; clk_en = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h00000000;
    reg_wr = 1'b0; reg_rd = 1'b0; lv = 7'h00; ev = 6'h00;
    tx_c = 16'h0000; tx_n = 16'h0000; rx_c = 16'h0000; rx_n = 16'h0000;
    m = 12'h000; sk = 32'h00000000; rs = 32'h00000026; pend = 1'b0; rd_d1 = 1'b0;
    mismatches = 0; n_checks = 0; cyc = 0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(OFS_STATUS);
    rd(OFS_IRQ_MASK);
    rd(OFS_IRQ_SET);
    rd(OFS_IRQ_CLR);
    rd(8'h10);
    idle();
    ck_irq();
    // random levels, counters and mask traffic
    for (int i = 0; i < 12; i++) begin
      rs = nxt(rs);
      idle();
      lv   <= rs[6:0];
      tx_c <= rs[7] ? 16'h0000 : rs[31:16];
      tx_n <= rs[8] ? 16'h0000 : rs[15:0];
      rx_c <= rs[9] ? 16'h0000 : rs[31:16];
      rx_n <= rs[10] ? 16'h0000 : rs[15:0];
      wr(i[0] ? OFS_IRQ_CLR : OFS_IRQ_SET, {rs[15:0], rs[31:16]});
      rd(OFS_IRQ_MASK);
      rd(OFS_STATUS);
      idle();
      ck_irq();
    end
    // writes to read-only, unmapped and frozen places
    wr(OFS_STATUS, 32'hFFFFFFFF);
    wr(OFS_IRQ_MASK, 32'hFFFFFFFF);
    wr(8'h10, 32'hFFFFFFFF);
    idle();
    clk_en <= 1'b0;
    wr(OFS_IRQ_SET, 32'h00000FFF);
    idle();
    clk_en <= 1'b1;
    rd(OFS_IRQ_MASK);
    idle();
    lv <= 7'h00; tx_c <= 16'h0001; rx_c <= 16'h0001;
    // each compare and frame sync event alone on the interrupt
    for (int i = 0; i < 4; i++) begin
      wr(OFS_IRQ_CLR, 32'h00000FFF);
      wr(OFS_IRQ_SET, 32'h00000001 << (8 + i));
      pulse(i);
      ck_irq();
      rd(OFS_STATUS);
      rd(OFS_STATUS);
      idle();
      ck_irq();
    end
    // overwrite of an unread word
    wr(OFS_IRQ_CLR, 32'h00000FFF);
    wr(OFS_IRQ_SET, 32'h00000020);
    pulse(4);
    pulse(5);
    pulse(4);
    ck_irq();
    pulse(4);
    ck_irq();
    wr(OFS_IRQ_CLR, 32'h00000020);
    idle();
    ck_irq();
    wr(OFS_IRQ_SET, 32'h00000020);
    idle();
    ck_irq();
    rd(OFS_STATUS);
    rd(OFS_STATUS);
    idle();
    repeat (2) @(posedge clock);
    chk("queue", 32'h00000000, exp_q.size());
    finish_test();
  end
endmodule
